// ===== pkg/uet_defines.vh
// Register map, field positions and codes for the USB endpoint transaction block
`ifndef UET_DEFINES_VH
`define UET_DEFINES_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define UET_HADDR_OFS 16'h1FEF
`define UET_FN_ADDR_REG_OFS 16'h1FEE
`define UET_GSTATE_OFS 16'h1FF2
`define UET_USB_IRQ_STATUS_REG_OFS 16'h1FF0
`define UET_USB_IRQ_ACK_REG_OFS 16'h1FF1
`define UET_CFG0_OFS 16'h1FE7
`define UET_CFG1_OFS 16'h0024
`define UET_CFG2_OFS 16'h1FE4
`define UET_CFG3_OFS 16'h1FE3
`define UET_CMD0_OFS 16'h1FA7
`define UET_CMD1_OFS 16'h1FDD
`define UET_CMD2_OFS 16'h1FDC
`define UET_CMD3_OFS 16'h1FDB
`define UET_STAT0_OFS 16'h1FA6
`define UET_STAT1_OFS 16'h1FD2
`define UET_STAT2_OFS 16'h1FD1
`define UET_STAT3_OFS 16'h1FD0
`define UET_DAT0_OFS 16'h1FD7
`define UET_DAT1_OFS 16'h1FD5
`define UET_DAT2_OFS 16'h1FD4
`define UET_DAT3_OFS 16'h1FD3

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define UET_REG_RST 8'h00
`define UET_CFG_WMASK 8'h8F
`define UET_B_EP_ON 7
`define UET_B_PID 3
`define UET_B_IN_SEL 2
`define UET_B_SINGLE 7
`define UET_B_FUNC_ON 7
`define UET_B_ADDR_EN 0
`define UET_FIFO_DEPTH 4'h8

// ----------------------------------------
// Token and answer codes
// ----------------------------------------
`define UET_TOK_SETUP 2'h0
`define UET_TOK_IN 2'h1
`define UET_TOK_OUT 2'h2
`define UET_RESP_ACK 2'h0
`define UET_RESP_NAK 2'h1
`define UET_RESP_STALL 2'h2
`define UET_RESP_DATA 2'h3

`endif

// ===== logic/uet_ep_mem.v
// Shared 4 x 8 byte endpoint FIFO storage
`timescale 1ns/100ps
module uet_ep_mem (
	input wire clk,
	input wire we,
	input wire [4:0] wr_addr,
	input wire [7:0] wr_data,
	input wire [4:0] rd_addr_a,
	output wire [7:0] rd_data_a,
	input wire [4:0] rd_addr_b,
	output wire [7:0] rd_data_b
);

	// No reset: contents are only read after being written
	reg [7:0] mem [0:31];

	always @(posedge clk) begin
		if (we) begin
			mem[wr_addr] <= wr_data;
		end
	end

	assign rd_data_a = mem[rd_addr_a];
	assign rd_data_b = mem[rd_addr_b];

endmodule

// ===== logic/uet_core.v
// Endpoint transaction engine with microcontroller register file
`timescale 1ns/100ps
`include "uet_defines.vh"

// Summary of operation
// [RULE_01] SETUP data stored, ACKed, setup_rcvd, interrupt
// [RULE_02] Status IN gets DATA1 zero length, then send_done
// [RULE_03] Control read IN: data if loaded, else NAK
// [RULE_04] Host ACK clears in_pkt_loaded, sets send_done
// [RULE_05] Read status OUT NAKed while send_done set
// [RULE_06] SETUP clears last_stage_flag
// [RULE_07] Control write OUT stored, ACKed, out_rcvd
// [RULE_08] Firmware programs command register after setup
// [RULE_09] Firmware acknowledges interrupts through irq_clear
// [RULE_10] Firmware ends write data stage with stall
// [RULE_11] New hub address used after enable bit
// [RULE_12] Hub address seven bits, resets to zero
// [RULE_13] Single address mode maps hub endpoint
// [RULE_14] func_on gates function, ignored in single mode
// [RULE_15] Function address seven bits, resets zero
// [RULE_16] ep_on enables each endpoint
// [RULE_17] pid_toggle flips after each good transaction
// [RULE_18] ep_in_sel picks direction, one is IN
// [RULE_19] Endpoint zero kind zero, reserved read zero
// [RULE_20] Unreadable bits read zero, unwritable ignored
// [RULE_21] Firmware sets direction, kind, enable first
// [RULE_22] Bulk IN NAKs until loaded, retries
// [RULE_23] Bulk OUT stored, ACKed, out_rcvd
// [RULE_24] OUT NAKed while out_rcvd, except SETUP
// [RULE_25] setup_rcvd clears other status bits
// [RULE_26] Interrupt held while events unacknowledged
// [RULE_27] Unexpected control token while stall_force STALLs
module uet_core (
	input wire CLK_SYS,
	input wire RST_B,
	input wire [15:0] BUS_ADDR,
	input wire [7:0] BUS_WDATA,
	input wire BUS_WR,
	input wire BUS_RD,
	output reg [7:0] BUS_RDATA,
	output reg IRQ,
	input wire TOK_VALID,
	input wire [1:0] TOK_TYPE,
	input wire [6:0] TOK_ADDR,
	input wire [3:0] TOK_EP,
	input wire RX_VALID,
	input wire [7:0] RX_BYTE,
	input wire RX_PID1,
	input wire RX_END,
	input wire HS_ACK,
	input wire HS_TIMEOUT,
	output reg RESP_VALID,
	output reg [1:0] RESP_CODE,
	output reg RESP_PID1,
	output reg [3:0] RESP_LEN,
	output reg TX_VALID,
	output reg [7:0] TX_BYTE,
	output reg TX_LAST
);

	// ----------------------------------------
	// States and receive modes
	// ----------------------------------------
	localparam ST_IDLE = 2'b00;
	localparam ST_RX = 2'b01;
	localparam ST_TX = 2'b10;
	localparam ST_ACK = 2'b11;
	localparam RXM_SETUP = 3'b000;
	localparam RXM_DATA = 3'b001;
	localparam RXM_STATUS = 3'b010;
	localparam RXM_NAK = 3'b011;
	localparam RXM_STALL = 3'b100;

	function [2:0] dec4;
		input [15:0] a;
		input [15:0] o0;
		input [15:0] o1;
		input [15:0] o2;
		input [15:0] o3;
		begin
			if (a == o0) begin
				dec4 = 3'b100;
			end else if (a == o1) begin
				dec4 = 3'b101;
			end else if (a == o2) begin
				dec4 = 3'b110;
			end else if (a == o3) begin
				dec4 = 3'b111;
			end else begin
				dec4 = 3'b000;
			end
		end
	endfunction

	// Saturates at FIFO depth so overruns never wrap into old data
	function [3:0] sat_inc;
		input [3:0] v;
		begin
			if (v < `UET_FIFO_DEPTH) begin
				sat_inc = v + 4'h1;
			end else begin
				sat_inc = v;
			end
		end
	endfunction

	// ----------------------------------------
	// Registers and state
	// ----------------------------------------
	integer i;
	reg [7:0] hub_addr_reg;
	reg [7:0] fn_addr_reg;
	reg [7:0] gstate;
	reg [6:0] active_hub_addr;
	reg [7:0] cfg [0:3];
	reg [3:0] cptr [0:3];
	reg [3:0] bcnt [0:3];
	reg [3:0] setup_rcvd;
	reg [3:0] out_rcvd;
	reg [3:0] send_done;
	reg [3:0] stall_sent;
	reg [3:0] ctl_read_sel;
	reg [3:0] last_stage_flag;
	reg [3:0] stall_force;
	reg [3:0] in_pkt_loaded;
	reg [3:0] irq_pend;
	reg [1:0] state;
	reg [2:0] rx_mode;
	reg [1:0] cur_ep;
	reg [3:0] uptr;
	reg [3:0] tx_len;
	reg tx_status;
	reg ev_setup;
	reg ev_out;
	reg ev_send;
	reg ev_clr_inpkt;
	reg ev_stall;
	reg ev_tog;
	reg [1:0] ev_ep;
	reg [3:0] ev_cnt;
	reg tok_hit;
	reg [1:0] tok_idx;
	reg [7:0] next_rdata;

	wire single_addr_mode = hub_addr_reg[`UET_B_SINGLE];
	wire func_on = fn_addr_reg[`UET_B_FUNC_ON];
	wire [2:0] cfg_d = dec4(BUS_ADDR, `UET_CFG0_OFS, `UET_CFG1_OFS, `UET_CFG2_OFS, `UET_CFG3_OFS);
	wire [2:0] cmd_d = dec4(BUS_ADDR, `UET_CMD0_OFS, `UET_CMD1_OFS, `UET_CMD2_OFS, `UET_CMD3_OFS);
	wire [2:0] stat_d = dec4(BUS_ADDR, `UET_STAT0_OFS, `UET_STAT1_OFS, `UET_STAT2_OFS, `UET_STAT3_OFS);
	wire [2:0] dat_d = dec4(BUS_ADDR, `UET_DAT0_OFS, `UET_DAT1_OFS, `UET_DAT2_OFS, `UET_DAT3_OFS);
	wire [1:0] dsel = dat_d[1:0];
	wire [3:0] dptr = cptr[dsel];
	wire tok_ctl = (tok_idx == 2'd1) || ((tok_idx == 2'd0) && !single_addr_mode); // see [RULE_13]
	wire [7:0] tok_cfg = cfg[tok_idx];
	wire [7:0] cur_cfg = cfg[cur_ep];
	wire rx_store = (state == ST_RX) && RX_VALID && (uptr < `UET_FIFO_DEPTH)
		&& ((rx_mode == RXM_SETUP) || (rx_mode == RXM_DATA));
	wire cpu_we = BUS_WR && dat_d[2] && (dptr < `UET_FIFO_DEPTH);
	wire [7:0] mem_a;
	wire [7:0] mem_b;

	// Receive path wins the single write port; firmware must not fill during a receive
	uet_ep_mem u_mem (
		.clk(CLK_SYS),
		.we(rx_store | cpu_we),
		.wr_addr(rx_store ? {cur_ep, uptr[2:0]} : {dsel, dptr[2:0]}),
		.wr_data(rx_store ? RX_BYTE : BUS_WDATA),
		.rd_addr_a({dsel, dptr[2:0]}),
		.rd_data_a(mem_a),
		.rd_addr_b({cur_ep, uptr[2:0]}),
		.rd_data_b(mem_b)
	);

	// ----------------------------------------
	// Token address and endpoint decode
	// ----------------------------------------
	// Hub wins when hub and function share an address, as both do after reset
	always @* begin
		tok_hit = 1'b0;
		tok_idx = 2'd0;
		if (single_addr_mode) begin
			if (TOK_ADDR == active_hub_addr && TOK_EP < 4'h4) begin // see [RULE_13] [RULE_14]
				tok_hit = 1'b1;
				tok_idx = (TOK_EP == 4'h3) ? 2'd0 : TOK_EP[1:0] + 2'd1;
			end
		end else if (TOK_ADDR == active_hub_addr && TOK_EP == 4'h0) begin // see [RULE_11]
			tok_hit = 1'b1;
		end else if (func_on && TOK_ADDR == fn_addr_reg[6:0] && TOK_EP < 4'h3) begin // see [RULE_14] [RULE_15]
			tok_hit = 1'b1;
			tok_idx = TOK_EP[1:0] + 2'd1;
		end
		tok_hit = tok_hit & cfg[tok_idx][`UET_B_EP_ON]; // see [RULE_16]
	end

	// ----------------------------------------
	// Register read decode
	// ----------------------------------------
	always @* begin
		next_rdata = 8'h00; // see [RULE_20]
		if (BUS_ADDR == `UET_HADDR_OFS) begin
			next_rdata = hub_addr_reg;
		end else if (BUS_ADDR == `UET_FN_ADDR_REG_OFS) begin
			next_rdata = fn_addr_reg;
		end else if (BUS_ADDR == `UET_GSTATE_OFS) begin
			next_rdata = gstate;
		end else if (BUS_ADDR == `UET_USB_IRQ_STATUS_REG_OFS) begin
			next_rdata = {4'h0, irq_pend};
		end else if (cfg_d[2]) begin
			next_rdata = cfg[cfg_d[1:0]]; // see [RULE_19]
		end else if (cmd_d[2]) begin
			next_rdata = {ctl_read_sel[cmd_d[1:0]], last_stage_flag[cmd_d[1:0]],
				stall_force[cmd_d[1:0]], in_pkt_loaded[cmd_d[1:0]], 4'h0};
		end else if (stat_d[2]) begin
			next_rdata = {4'h0, stall_sent[stat_d[1:0]], setup_rcvd[stat_d[1:0]],
				out_rcvd[stat_d[1:0]], send_done[stat_d[1:0]]};
		end else if (dat_d[2]) begin
			next_rdata = mem_a;
		end
	end

	// ----------------------------------------
	// Register file and endpoint flags
	// ----------------------------------------
	// Hardware sets are applied last so an event beats a same-cycle clear
	always @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			hub_addr_reg <= `UET_REG_RST; // see [RULE_12]
			fn_addr_reg <= `UET_REG_RST; // see [RULE_15]
			gstate <= `UET_REG_RST;
			active_hub_addr <= 7'h00;
			setup_rcvd <= 4'h0;
			out_rcvd <= 4'h0;
			send_done <= 4'h0;
			stall_sent <= 4'h0;
			ctl_read_sel <= 4'h0;
			last_stage_flag <= 4'h0;
			stall_force <= 4'h0;
			in_pkt_loaded <= 4'h0;
			irq_pend <= 4'h0;
			IRQ <= 1'b0;
			BUS_RDATA <= 8'h00;
			for (i = 0; i < 4; i = i + 1) begin
				cfg[i] <= `UET_REG_RST;
				cptr[i] <= 4'h0;
				bcnt[i] <= 4'h0;
			end
		end else begin
			BUS_RDATA <= BUS_RD ? next_rdata : 8'h00;
			IRQ <= |irq_pend; // see [RULE_26]
			if (BUS_WR) begin
				if (BUS_ADDR == `UET_HADDR_OFS) begin
					hub_addr_reg <= BUS_WDATA;
				end else if (BUS_ADDR == `UET_FN_ADDR_REG_OFS) begin
					fn_addr_reg <= BUS_WDATA;
				end else if (BUS_ADDR == `UET_GSTATE_OFS) begin
					gstate <= BUS_WDATA;
					if (BUS_WDATA[`UET_B_ADDR_EN]) begin
						active_hub_addr <= hub_addr_reg[6:0]; // see [RULE_11]
					end
				end else if (BUS_ADDR == `UET_USB_IRQ_ACK_REG_OFS) begin
					irq_pend <= irq_pend & ~BUS_WDATA[3:0]; // see [RULE_09]
				end
			end
			for (i = 0; i < 4; i = i + 1) begin
				if (BUS_WR && cfg_d[2] && cfg_d[1:0] == i[1:0]) begin
					cfg[i] <= BUS_WDATA & `UET_CFG_WMASK; // see [RULE_18] [RULE_20]
				end
				if (BUS_WR && cmd_d[2] && cmd_d[1:0] == i[1:0]) begin
					ctl_read_sel[i] <= BUS_WDATA[7]; // see [RULE_08]
					last_stage_flag[i] <= BUS_WDATA[6];
					stall_force[i] <= BUS_WDATA[5];
					in_pkt_loaded[i] <= BUS_WDATA[4];
					if (BUS_WDATA[3]) begin
						stall_sent[i] <= 1'b0;
					end
					if (BUS_WDATA[2]) begin
						setup_rcvd[i] <= 1'b0;
					end
					if (BUS_WDATA[1]) begin
						out_rcvd[i] <= 1'b0;
					end
					if (BUS_WDATA[0]) begin
						send_done[i] <= 1'b0;
					end
				end
				if (dat_d[2] && dsel == i[1:0]) begin
					if (BUS_WR) begin
						cptr[i] <= sat_inc(dptr);
						bcnt[i] <= sat_inc(dptr);
					end else if (BUS_RD) begin
						cptr[i] <= sat_inc(dptr);
					end
				end
				if (ev_ep == i[1:0]) begin
					if (ev_tog) begin
						cfg[i][`UET_B_PID] <= ~cfg[i][`UET_B_PID]; // see [RULE_17]
					end
					if (ev_setup) begin
						cfg[i][`UET_B_PID] <= 1'b1; // see [RULE_17]
						setup_rcvd[i] <= 1'b1; // see [RULE_01]
						out_rcvd[i] <= 1'b0; // see [RULE_25]
						send_done[i] <= 1'b0;
						stall_sent[i] <= 1'b0;
						last_stage_flag[i] <= 1'b0; // see [RULE_06]
					end
					if (ev_out) begin
						out_rcvd[i] <= 1'b1; // see [RULE_07] [RULE_23]
						bcnt[i] <= ev_cnt;
					end
					if (ev_send) begin
						send_done[i] <= 1'b1; // see [RULE_02] [RULE_04]
					end
					if (ev_clr_inpkt) begin
						in_pkt_loaded[i] <= 1'b0; // see [RULE_04] [RULE_22]
					end
					if (ev_stall) begin
						stall_sent[i] <= 1'b1;
					end
					if (ev_setup | ev_out | ev_send | ev_stall) begin
						irq_pend[i] <= 1'b1; // see [RULE_26]
						cptr[i] <= 4'h0;
					end
				end
			end
		end
	end

	// ----------------------------------------
	// Transaction sequencer
	// ----------------------------------------
	always @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			state <= ST_IDLE;
			rx_mode <= RXM_NAK;
			cur_ep <= 2'd0;
			uptr <= 4'h0;
			tx_len <= 4'h0;
			tx_status <= 1'b0;
			ev_setup <= 1'b0;
			ev_out <= 1'b0;
			ev_send <= 1'b0;
			ev_clr_inpkt <= 1'b0;
			ev_stall <= 1'b0;
			ev_tog <= 1'b0;
			ev_ep <= 2'd0;
			ev_cnt <= 4'h0;
			RESP_VALID <= 1'b0;
			RESP_CODE <= `UET_RESP_ACK;
			RESP_PID1 <= 1'b0;
			RESP_LEN <= 4'h0;
			TX_VALID <= 1'b0;
			TX_BYTE <= 8'h00;
			TX_LAST <= 1'b0;
		end else begin
			RESP_VALID <= 1'b0;
			TX_VALID <= 1'b0;
			TX_LAST <= 1'b0;
			ev_setup <= 1'b0;
			ev_out <= 1'b0;
			ev_send <= 1'b0;
			ev_clr_inpkt <= 1'b0;
			ev_stall <= 1'b0;
			ev_tog <= 1'b0;
			ev_ep <= cur_ep;
			case (state)
				ST_IDLE: begin
					if (TOK_VALID && tok_hit) begin
						cur_ep <= tok_idx;
						uptr <= 4'h0;
						if (TOK_TYPE == `UET_TOK_SETUP) begin
							// Early SETUP is taken even over unread OUT data
							rx_mode <= tok_ctl ? RXM_SETUP : RXM_STALL; // see [RULE_01] [RULE_24]
							state <= ST_RX;
						end else if (TOK_TYPE == `UET_TOK_OUT) begin
							state <= ST_RX;
							if (tok_ctl && ctl_read_sel[tok_idx]) begin
								if (send_done[tok_idx] || out_rcvd[tok_idx]) begin
									rx_mode <= RXM_NAK; // see [RULE_05]
								end else begin
									rx_mode <= RXM_STATUS; // see [RULE_05]
								end
							end else if (tok_ctl && last_stage_flag[tok_idx] && stall_force[tok_idx]) begin
								rx_mode <= RXM_STALL; // see [RULE_27]
							end else if (!tok_ctl && tok_cfg[`UET_B_IN_SEL]) begin
								rx_mode <= RXM_STALL; // see [RULE_18]
							end else if (out_rcvd[tok_idx]) begin
								rx_mode <= RXM_NAK; // see [RULE_24]
							end else begin
								rx_mode <= RXM_DATA; // see [RULE_07] [RULE_23]
							end
						end else if (TOK_TYPE == `UET_TOK_IN) begin
							RESP_VALID <= 1'b1;
							RESP_LEN <= 4'h0;
							RESP_PID1 <= 1'b1;
							if (tok_ctl && last_stage_flag[tok_idx] && !ctl_read_sel[tok_idx]) begin
								RESP_CODE <= `UET_RESP_DATA; // see [RULE_02]
								tx_status <= 1'b1;
								tx_len <= 4'h0;
								state <= ST_ACK;
							end else if ((tok_ctl && ctl_read_sel[tok_idx] && !last_stage_flag[tok_idx])
								|| (!tok_ctl && tok_cfg[`UET_B_IN_SEL])) begin
								if (in_pkt_loaded[tok_idx]) begin
									RESP_CODE <= `UET_RESP_DATA; // see [RULE_03] [RULE_22]
									RESP_PID1 <= tok_cfg[`UET_B_PID];
									RESP_LEN <= bcnt[tok_idx];
									tx_status <= 1'b0;
									tx_len <= bcnt[tok_idx];
									state <= (bcnt[tok_idx] == 4'h0) ? ST_ACK : ST_TX;
								end else begin
									RESP_CODE <= `UET_RESP_NAK; // see [RULE_03] [RULE_22]
								end
							end else if (!tok_ctl || stall_force[tok_idx]) begin
								RESP_CODE <= `UET_RESP_STALL; // see [RULE_27]
								ev_stall <= 1'b1;
								ev_ep <= tok_idx;
							end else begin
								RESP_CODE <= `UET_RESP_NAK;
							end
						end
					end
				end
				ST_RX: begin
					if (rx_store) begin
						uptr <= sat_inc(uptr);
					end
					if (TOK_VALID) begin
						state <= ST_IDLE;
					end else if (RX_END) begin
						state <= ST_IDLE;
						RESP_VALID <= 1'b1;
						RESP_CODE <= `UET_RESP_ACK;
						ev_cnt <= uptr;
						if (rx_mode == RXM_SETUP) begin
							ev_setup <= 1'b1; // see [RULE_01]
						end else if (rx_mode == RXM_STATUS) begin
							ev_out <= 1'b1; // see [RULE_05]
						end else if (rx_mode == RXM_DATA) begin
							// A repeated packet with a stale PID is ACKed but not flagged; its bytes still overwrite the FIFO
							if (RX_PID1 == cur_cfg[`UET_B_PID]) begin
								ev_out <= 1'b1; // see [RULE_07] [RULE_23]
								ev_tog <= 1'b1; // see [RULE_17]
							end
						end else if (rx_mode == RXM_NAK) begin
							RESP_CODE <= `UET_RESP_NAK; // see [RULE_24]
						end else begin
							RESP_CODE <= `UET_RESP_STALL; // see [RULE_27]
							ev_stall <= 1'b1;
						end
					end
				end
				ST_TX: begin
					TX_VALID <= 1'b1;
					TX_BYTE <= mem_b;
					uptr <= sat_inc(uptr);
					if (sat_inc(uptr) >= tx_len) begin
						TX_LAST <= 1'b1;
						state <= ST_ACK;
					end
				end
				default: begin
					// Loaded data stays put, so a lost ACK means a retry on the next IN
					if (HS_ACK) begin
						state <= ST_IDLE;
						ev_send <= 1'b1; // see [RULE_02] [RULE_04]
						ev_clr_inpkt <= ~tx_status; // see [RULE_04]
						ev_tog <= ~tx_status; // see [RULE_17]
					end else if (HS_TIMEOUT) begin
						state <= ST_IDLE; // see [RULE_04] [RULE_22]
					end
				end
			endcase
		end
	end

endmodule

// ===== sim/uet_monitor.sv
// Port-level assertion checker for the endpoint transaction engine
`timescale 1ns/100ps
`include "uet_defines.vh"
module uet_monitor (
	input logic CLK_SYS,
	input logic RST_B,
	input logic [15:0] BUS_ADDR,
	input logic [7:0] BUS_WDATA,
	input logic BUS_WR,
	input logic BUS_RD,
	input logic [7:0] BUS_RDATA,
	input logic IRQ,
	input logic TOK_VALID,
	input logic [1:0] TOK_TYPE,
	input logic [6:0] TOK_ADDR,
	input logic [3:0] TOK_EP,
	input logic RX_VALID,
	input logic [7:0] RX_BYTE,
	input logic RX_PID1,
	input logic RX_END,
	input logic HS_ACK,
	input logic HS_TIMEOUT,
	input logic RESP_VALID,
	input logic [1:0] RESP_CODE,
	input logic RESP_PID1,
	input logic [3:0] RESP_LEN,
	input logic TX_VALID,
	input logic [7:0] TX_BYTE,
	input logic TX_LAST
);
	logic [3:0] tx_n;
	logic [3:0] tx_len;
	wire usb_irq_ack_reg_wr = BUS_WR && BUS_ADDR == `UET_USB_IRQ_ACK_REG_OFS;
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_B);
	// Payload bytes counted since the last header
	always @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			tx_n <= 4'h0;
			tx_len <= 4'h0;
		end else if (RESP_VALID) begin
			tx_n <= 4'h0;
			tx_len <= RESP_LEN;
		end else if (TX_VALID) begin
			tx_n <= tx_n + 4'h1;
		end
	end
	sequence s_data_hdr;
		RESP_VALID && RESP_CODE == `UET_RESP_DATA && RESP_LEN != 4'h0;
	endsequence
	sequence s_quiet_hdr;
		RESP_VALID && (RESP_CODE != `UET_RESP_DATA || RESP_LEN == 4'h0);
	endsequence
	sequence s_haddr_rw;
		BUS_WR && BUS_ADDR == `UET_HADDR_OFS ##2 BUS_RD && BUS_ADDR == `UET_HADDR_OFS;
	endsequence
	AST_TX_FOLLOWS: assert property (s_data_hdr |=> TX_VALID)
		else $error("payload missing after data header");
	AST_TX_COUNT: assert property (TX_VALID && TX_LAST |-> tx_n + 4'h1 == tx_len)
		else $error("payload length differs from header");
	AST_NO_TX: assert property (s_quiet_hdr |=> !TX_VALID)
		else $error("payload after empty or handshake answer");
	AST_ANSWER_CAUSE: assert property (RESP_VALID |-> $past(TOK_VALID && TOK_TYPE == `UET_TOK_IN) || $past(RX_END))
		else $error("answer without token or packet end");
	AST_RDATA_IDLE: assert property (!$past(BUS_RD) |-> BUS_RDATA == 8'h00)
		else $error("read data without read");
	AST_CFG_RSVD: assert property ($past(BUS_RD && BUS_ADDR == `UET_CFG0_OFS) |-> BUS_RDATA[6:4] == 3'h0)
		else $error("reserved config bits not zero");
	AST_HADDR_BACK: assert property (s_haddr_rw |=> BUS_RDATA == $past(BUS_WDATA, 3))
		else $error("hub address readback wrong");
	AST_IRQ_HELD: assert property (IRQ && !usb_irq_ack_reg_wr && !$past(usb_irq_ack_reg_wr) |=> IRQ)
		else $error("interrupt dropped without acknowledge");
endmodule
bind uet_core uet_monitor uet_monitor_i (.*);

// ===== sim/uet_host_model.sv
// Behavioural host: tokens, data packets and handshakes
`timescale 1ns/100ps
`include "uet_defines.vh"
module uet_host_model (
	input logic clk,
	output logic tok_valid,
	output logic [1:0] tok_type,
	output logic [6:0] tok_addr,
	output logic [3:0] tok_ep,
	output logic rx_valid,
	output logic [7:0] rx_byte,
	output logic rx_pid1,
	output logic rx_end,
	output logic hs_ack,
	output logic hs_timeout,
	input logic resp_valid,
	input logic [1:0] resp_code,
	input logic [3:0] resp_len,
	input logic tx_last
);
	logic [7:0] pay [8];
	initial begin
		{tok_valid, rx_valid, rx_end, hs_ack, hs_timeout, rx_pid1} = '0;
		{tok_type, tok_addr, tok_ep, rx_byte} = '0;
	end
	task automatic send_tok(input logic [1:0] t, input logic [6:0] a, input logic [3:0] e);
		@(negedge clk);
		tok_valid = 1'b1;
		tok_type = t;
		tok_addr = a;
		tok_ep = e;
		@(negedge clk);
		tok_valid = 1'b0;
	endtask
	task automatic xfer_out(input logic [1:0] t, input logic [6:0] a, input logic [3:0] e, input logic p, input int n);
		send_tok(t, a, e);
		for (int k = 0; k < n; k++) begin
			rx_valid = 1'b1;
			rx_byte = pay[k];
			@(negedge clk);
		end
		rx_valid = 1'b0;
		// Idle byte lane flips so stale data is never mistaken for fresh
		rx_byte = ~rx_byte;
		rx_end = 1'b1;
		rx_pid1 = p;
		@(negedge clk);
		rx_end = 1'b0;
		repeat (4) @(negedge clk);
	endtask
	task automatic xfer_in(input logic [6:0] a, input logic [3:0] e, input logic ack);
		int w;
		send_tok(`UET_TOK_IN, a, e);
		w = 0;
		if (resp_valid === 1'b1 && resp_code === `UET_RESP_DATA) begin
			while (resp_len !== 4'h0 && tx_last !== 1'b1 && w < 12) begin
				@(negedge clk);
				w++;
			end
			// Random handshake delay covers prompt and slow hosts
			repeat ($urandom_range(3)) @(negedge clk);
			hs_ack = ack;
			hs_timeout = !ack;
			@(negedge clk);
			hs_ack = 1'b0;
			hs_timeout = 1'b0;
		end
		repeat (4) @(negedge clk);
	endtask
endmodule

// ===== sim/test_usb_endpoint_transactions.sv
// Self-checking bench for the endpoint transaction engine
`timescale 1ns/100ps
`include "uet_defines.vh"
module test_usb_endpoint_transactions;
	logic CLK_SYS, RST_B, BUS_WR, BUS_RD, IRQ, TOK_VALID, RX_VALID, RX_PID1, RX_END, HS_ACK, HS_TIMEOUT;
	logic RESP_VALID, RESP_PID1, TX_VALID, TX_LAST, rd_seen;
	logic [15:0] BUS_ADDR;
	logic [7:0] BUS_WDATA, BUS_RDATA, RX_BYTE, TX_BYTE;
	logic [6:0] TOK_ADDR, hub;
	logic [3:0] TOK_EP, RESP_LEN;
	logic [1:0] TOK_TYPE, RESP_CODE;
	int mismatches, n_checks, cyc;
	logic [15:0] rd_q [$];
	logic [6:0] resp_q [$];
	logic [7:0] tx_q [$];
	logic [7:0] keep [8];
	localparam logic [6:0] ack_r = {`UET_RESP_ACK, 5'h00};
	localparam logic [6:0] nak_r = {`UET_RESP_NAK, 5'h00};
	localparam logic [6:0] stl_r = {`UET_RESP_STALL, 5'h00};
	uet_core uet_core_i (.*);
	uet_host_model uet_host_model_i (.clk(CLK_SYS), .tok_valid(TOK_VALID), .tok_type(TOK_TYPE),
		.tok_addr(TOK_ADDR), .tok_ep(TOK_EP), .rx_valid(RX_VALID), .rx_byte(RX_BYTE), .rx_pid1(RX_PID1),
		.rx_end(RX_END), .hs_ack(HS_ACK), .hs_timeout(HS_TIMEOUT), .resp_valid(RESP_VALID),
		.resp_code(RESP_CODE), .resp_len(RESP_LEN), .tx_last(TX_LAST));
	initial begin
		CLK_SYS = 1'b0;
		forever #10 CLK_SYS = ~CLK_SYS;
	end
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk_resp(input logic [6:0] exp);
		n_checks++;
		if (RESP_CODE !== exp[6:5] || (exp[6:5] == `UET_RESP_DATA && {RESP_PID1, RESP_LEN} !== exp[4:0])) begin
			mismatches++;
			$display("unexpected answer: expected %h seen %h", exp, {RESP_CODE, RESP_PID1, RESP_LEN});
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge CLK_SYS);
		BUS_ADDR = a;
		BUS_WDATA = d;
		BUS_WR = 1'b1;
		@(negedge CLK_SYS);
		BUS_WR = 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] m, input logic [7:0] e);
		@(negedge CLK_SYS);
		BUS_ADDR = a;
		BUS_RD = 1'b1;
		rd_q.push_back({m, e & m});
		@(negedge CLK_SYS);
		BUS_RD = 1'b0;
	endtask
	task automatic load_pay(input int n);
		for (int k = 0; k < n; k++) begin
			keep[k] = 8'($urandom);
			uet_host_model_i.pay[k] = keep[k];
		end
	endtask
	task automatic exp_data(input logic p, input int n);
		resp_q.push_back({`UET_RESP_DATA, p, 4'(n)});
		for (int k = 0; k < n; k++) tx_q.push_back(keep[k]);
	endtask
	// ----------------------------------------
	// Output watcher
	// ----------------------------------------
	always @(posedge CLK_SYS) rd_seen <= BUS_RD;
	always @(posedge CLK_SYS) begin
		cyc++;
		if (cyc == 16'h1388) begin
			mismatches++;
			close_out();
		end
	end
	always @(negedge CLK_SYS) begin
		if (rd_seen === 1'b1) begin
			chk_byte("read data", rd_q[0][7:0], BUS_RDATA & rd_q[0][15:8]);
			rd_q.pop_front();
		end
		if (RESP_VALID === 1'b1) chk_resp(resp_q.size() > 0 ? resp_q.pop_front() : 7'h7F);
		if (TX_VALID === 1'b1) chk_byte("payload", tx_q.size() > 0 ? tx_q.pop_front() : ~TX_BYTE, TX_BYTE);
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		RST_B = 1'b0;
		{BUS_WR, BUS_RD, BUS_ADDR, BUS_WDATA} = '0;
		void'($urandom(32'h2107_0a90));
		repeat (2) @(posedge CLK_SYS);
		@(negedge CLK_SYS);
		RST_B = 1'b1;
		rd(`UET_HADDR_OFS, 8'hFF, 8'h00);
		rd(`UET_FN_ADDR_REG_OFS, 8'hFF, 8'h00);
		wr(`UET_CFG0_OFS, 8'hFF);
		rd(`UET_CFG0_OFS, 8'hFF, 8'h8F);
		wr(`UET_CFG0_OFS, 8'h00);
		rd(16'h1234, 8'hFF, 8'h00);
		wr(`UET_FN_ADDR_REG_OFS, 8'h85);
		wr(`UET_CFG1_OFS, 8'h80);
		load_pay(8);
		resp_q.push_back(ack_r);
		uet_host_model_i.xfer_out(`UET_TOK_SETUP, 7'h05, 4'h0, 1'b0, 8);
		chk_byte("irq", 8'h01, {7'h00, IRQ});
		rd(`UET_USB_IRQ_STATUS_REG_OFS, 8'h0F, 8'h02);
		rd(`UET_STAT1_OFS, 8'hFF, 8'h04);
		wr(`UET_USB_IRQ_ACK_REG_OFS, 8'h02);
		repeat (2) @(negedge CLK_SYS);
		chk_byte("irq", 8'h00, {7'h00, IRQ});
		wr(`UET_CMD1_OFS, 8'h84);
		resp_q.push_back(nak_r);
		uet_host_model_i.xfer_in(7'h05, 4'h0, 1'b1);
		for (int k = 0; k < 2; k++) wr(`UET_DAT1_OFS, keep[k]);
		wr(`UET_CMD1_OFS, 8'h90);
		exp_data(1'b1, 2);
		uet_host_model_i.xfer_in(7'h05, 4'h0, 1'b0);
		exp_data(1'b1, 2);
		uet_host_model_i.xfer_in(7'h05, 4'h0, 1'b1);
		rd(`UET_CMD1_OFS, 8'hF0, 8'h80);
		rd(`UET_STAT1_OFS, 8'hFF, 8'h01);
		resp_q.push_back(nak_r);
		uet_host_model_i.xfer_out(`UET_TOK_OUT, 7'h05, 4'h0, 1'b1, 0);
		wr(`UET_CMD1_OFS, 8'h81);
		resp_q.push_back(ack_r);
		uet_host_model_i.xfer_out(`UET_TOK_OUT, 7'h05, 4'h0, 1'b1, 0);
		rd(`UET_STAT1_OFS, 8'h03, 8'h02);
		resp_q.push_back(nak_r);
		uet_host_model_i.xfer_out(`UET_TOK_OUT, 7'h05, 4'h0, 1'b1, 0);
		wr(`UET_CMD1_OFS, 8'h60);
		load_pay(8);
		resp_q.push_back(ack_r);
		uet_host_model_i.xfer_out(`UET_TOK_SETUP, 7'h05, 4'h0, 1'b0, 8);
		rd(`UET_STAT1_OFS, 8'hFF, 8'h04);
		rd(`UET_CMD1_OFS, 8'h40, 8'h00);
		for (int k = 0; k < 8; k++) rd(`UET_DAT1_OFS, 8'hFF, keep[k]);
		wr(`UET_CMD1_OFS, 8'h64);
		load_pay(2);
		resp_q.push_back(stl_r);
		uet_host_model_i.xfer_out(`UET_TOK_OUT, 7'h05, 4'h0, 1'b1, 2);
		exp_data(1'b1, 0);
		uet_host_model_i.xfer_in(7'h05, 4'h0, 1'b1);
		rd(`UET_STAT1_OFS, 8'h07, 8'h01);
		wr(`UET_USB_IRQ_ACK_REG_OFS, 8'h0F);
		wr(`UET_CFG2_OFS, 8'h86);
		rd(`UET_CFG2_OFS, 8'hFF, 8'h86);
		resp_q.push_back(nak_r);
		uet_host_model_i.xfer_in(7'h05, 4'h1, 1'b1);
		load_pay(3);
		for (int k = 0; k < 3; k++) wr(`UET_DAT2_OFS, keep[k]);
		wr(`UET_CMD2_OFS, 8'h10);
		exp_data(1'b0, 3);
		uet_host_model_i.xfer_in(7'h05, 4'h1, 1'b1);
		rd(`UET_CFG2_OFS, 8'hFF, 8'h8E);
		rd(`UET_CMD2_OFS, 8'h10, 8'h00);
		wr(`UET_CFG3_OFS, 8'h82);
		load_pay(4);
		resp_q.push_back(ack_r);
		uet_host_model_i.xfer_out(`UET_TOK_OUT, 7'h05, 4'h2, 1'b0, 4);
		rd(`UET_STAT3_OFS, 8'h02, 8'h02);
		for (int k = 0; k < 4; k++) uet_host_model_i.pay[k] = ~keep[k];
		resp_q.push_back(nak_r);
		uet_host_model_i.xfer_out(`UET_TOK_OUT, 7'h05, 4'h2, 1'b1, 4);
		for (int k = 0; k < 4; k++) rd(`UET_DAT3_OFS, 8'hFF, keep[k]);
		wr(`UET_FN_ADDR_REG_OFS, 8'h05);
		uet_host_model_i.xfer_in(7'h05, 4'h1, 1'b1);
		hub = 7'($urandom_range(6, 127));
		wr(`UET_HADDR_OFS, {1'b0, hub});
		rd(`UET_HADDR_OFS, 8'hFF, {1'b0, hub});
		wr(`UET_CFG0_OFS, 8'h80);
		uet_host_model_i.xfer_out(`UET_TOK_SETUP, hub, 4'h0, 1'b0, 8);
		wr(`UET_GSTATE_OFS, 8'h01);
		resp_q.push_back(ack_r);
		uet_host_model_i.xfer_out(`UET_TOK_SETUP, hub, 4'h0, 1'b0, 8);
		close_out();
	end
endmodule
